// *** logic/cmwss_sequencer.v ***
`default_nettype none
`include "cmwss_defines.vh"
module cmwss_sequencer #(
    parameter ADDR_W = 32
) (
    input  wire              ref_clk,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] cpuAddr,
    input  wire              memReqN,
    input  wire              seqCycle,
    input  wire              readCycle,
    input  wire              extReady,
    output wire              procClk,
    output wire              addrLatchEn,
    output reg  [ADDR_W-1:0] latchedAddr,
    output reg               procRun,
    output reg               sram_select_n,
    output reg               romSelectN,
    output reg  [1:0]        rom_byte_index,
    output reg  [1:0]        wait_phase_counter,
    output reg               ioStrobeN,
    output reg               extSelectN
);
    // ----------------------------------------
    // clocks and address latch
    // ----------------------------------------
    assign procClk     = ~ref_clk;
    assign addrLatchEn = ref_clk;

    // ----------------------------------------
    // address latch
    // ----------------------------------------
    // the clock doubles as latch enable, so the latch opens once per cycle
    // and a new early address only flows once the active phase is over
    // transparent latch kept deliberately: addresses must flow while enable high
    always @* begin
        if (addrLatchEn) begin
            latchedAddr = cpuAddr;
        end else begin
            latchedAddr = latchedAddr;
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire [1:0] region  = cpuAddr[ADDR_W-1:ADDR_W-2];
    wire       isRam   = (region == `CMWSS_RGN_RAM);
    wire       isExt   = (region == `CMWSS_RGN_EXT);
    // io and rom are told apart later from the region kept at decode
    wire       isSeq   = ~memReqN & seqCycle;

    reg  [3:0] state_r;
    reg  [3:0] state_nxt;
    reg  [1:0] regn_r;
    reg  [1:0] regn_nxt;
    reg        write_r;
    reg        write_nxt;
    reg  [1:0] byte_nxt;
    reg  [1:0] wait_nxt;
    reg        run_nxt;
    reg        sramSelNxt;
    reg        romSelNxt;
    reg        ioStbNxt;
    reg        extSelNxt;

    // ----------------------------------------
    // request qualifiers
    // ----------------------------------------
    // a sequential ram or external read in the same region stays in the access state, external only with ready high
    wire       seqRamRead  = isSeq & readCycle & isRam & (regn_r == `CMWSS_RGN_RAM);
    wire       seqExtRead  = isSeq & readCycle & isExt & (regn_r == `CMWSS_RGN_EXT);
    // sequential external writes still take their precharge tick
    wire       seqExtWrite = isSeq & ~readCycle & isExt & (regn_r == `CMWSS_RGN_EXT);
    // ram read requested while the core is stalled in decode
    wire       newRamRead  = ~memReqN & readCycle & isRam;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        regn_nxt  = regn_r;
        write_nxt = write_r;
        byte_nxt  = rom_byte_index;
        wait_nxt  = wait_phase_counter;
        case (state_r)
            `CMWSS_ST_DEC: begin
                regn_nxt  = region;
                write_nxt = ~readCycle;
                byte_nxt  = `CMWSS_BYTE_START;
                wait_nxt  = `CMWSS_WAIT_START;
                if (memReqN) begin
                    // nothing requested: behave as an internal cycle
                    state_nxt = `CMWSS_ST_INT;
                end else if (isRam & readCycle) begin
                    state_nxt = `CMWSS_ST_MEM;
                end else begin
                    // writes and slow regions spend one or more cycles in wait first
                    state_nxt = `CMWSS_ST_WAIT;
                end
            end
            `CMWSS_ST_WAIT: begin
                if (regn_r == `CMWSS_RGN_EXT) begin
                    if (extReady) begin
                        state_nxt = `CMWSS_ST_MEM;
                    end else begin
                        state_nxt = `CMWSS_ST_WAIT;
                    end
                end else if (regn_r == `CMWSS_RGN_RAM) begin
                    state_nxt = `CMWSS_ST_MEM;
                end else begin
                    if (wait_phase_counter == `CMWSS_WAIT_LAST) begin
                        wait_nxt = `CMWSS_WAIT_START;
                        if (regn_r == `CMWSS_RGN_IO || rom_byte_index == `CMWSS_BYTE_LAST) begin
                            state_nxt = `CMWSS_ST_MEM;
                        end else begin
                            byte_nxt = rom_byte_index - 2'h1;
                        end
                    end else begin
                        wait_nxt = wait_phase_counter - 2'h1;
                    end
                end
            end
            `CMWSS_ST_MEM, `CMWSS_ST_INT: begin
                wait_nxt = `CMWSS_WAIT_START;
                byte_nxt = `CMWSS_BYTE_START;
                if (memReqN) begin
                    state_nxt = `CMWSS_ST_INT;
                end else if (state_r == `CMWSS_ST_INT && seqCycle) begin
                    // address already valid during internal cycle
                    regn_nxt  = region;
                    write_nxt = ~readCycle;
                    if ((isRam | (isExt & extReady)) & readCycle) begin
                        state_nxt = `CMWSS_ST_MEM;
                    end else begin
                        state_nxt = `CMWSS_ST_WAIT;
                    end
                end else if (seqRamRead) begin
                    state_nxt = `CMWSS_ST_MEM;
                end else if (seqExtRead) begin
                    // ready high lets a burst read go on with no wait state
                    if (extReady) begin
                        state_nxt = `CMWSS_ST_MEM;
                    end else begin
                        state_nxt = `CMWSS_ST_WAIT;
                    end
                end else if (seqExtWrite) begin
                    write_nxt = 1'h1;
                    state_nxt = `CMWSS_ST_WAIT;
                end else begin
                    state_nxt = `CMWSS_ST_DEC;
                end
            end
            default: begin
                state_nxt = `CMWSS_ST_DEC;
            end
        endcase
        run_nxt = (state_nxt == `CMWSS_ST_MEM) || (state_nxt == `CMWSS_ST_INT);
    end

    // ----------------------------------------
    // chip select and strobe next values
    // ----------------------------------------
    // worked out from the next state so every select is a plain flop output
    always @* begin
        sramSelNxt = 1'h0;
        romSelNxt  = 1'h0;
        ioStbNxt   = 1'h0;
        extSelNxt  = 1'h0;
        case (state_nxt)
            `CMWSS_ST_DEC: begin
                // only a read may be selected early: a write here would be strobed
                // by the rising edge before the core's data out is stable
                sramSelNxt = newRamRead;
            end
            `CMWSS_ST_WAIT: begin
                // a ram write spends its extra decode tick here, deselected
                sramSelNxt = (regn_nxt == `CMWSS_RGN_RAM) & ~write_nxt;
                romSelNxt  = (regn_nxt == `CMWSS_RGN_ROM);
                // strobe covers the tail of the count, leaving address set-up first
                ioStbNxt   = (regn_nxt == `CMWSS_RGN_IO) && (wait_nxt <= `CMWSS_IO_STROBE);
                extSelNxt  = (regn_nxt == `CMWSS_RGN_EXT);
            end
            `CMWSS_ST_MEM: begin
                // held across a burst; a write's rising edge comes on leaving this state
                sramSelNxt = (regn_nxt == `CMWSS_RGN_RAM);
                extSelNxt  = (regn_nxt == `CMWSS_RGN_EXT);
            end
            default: begin
                // internal cycles select nothing
                sramSelNxt = 1'h0;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r            <= `CMWSS_ST_DEC;
            regn_r             <= `CMWSS_RGN_RAM;
            write_r            <= 1'h0;
            rom_byte_index     <= `CMWSS_BYTE_START;
            wait_phase_counter <= `CMWSS_WAIT_START;
            procRun            <= 1'h0;
            sram_select_n      <= 1'h1;
            romSelectN         <= 1'h1;
            ioStrobeN          <= 1'h1;
            extSelectN         <= 1'h1;
        end else begin
            state_r            <= state_nxt;
            regn_r             <= regn_nxt;
            write_r            <= write_nxt;
            rom_byte_index     <= byte_nxt;
            wait_phase_counter <= wait_nxt;
            procRun            <= run_nxt;
            // registered so no decode glitch reaches a chip select
            sram_select_n      <= ~sramSelNxt;
            romSelectN         <= ~romSelNxt;
            ioStrobeN          <= ~ioStbNxt;
            extSelectN         <= ~extSelNxt;
        end
    end
endmodule
`default_nettype wire

// *** logic/cmwss_defines.vh ***
`ifndef CMWSS_DEFINES_VH
`define CMWSS_DEFINES_VH
// ----------------------------------------
// states, one-hot
// ----------------------------------------
`define CMWSS_ST_DEC   4'h1
`define CMWSS_ST_WAIT  4'h2
`define CMWSS_ST_MEM   4'h4
`define CMWSS_ST_INT   4'h8
// ----------------------------------------
// address region codes on a[31:30]
// ----------------------------------------
`define CMWSS_RGN_RAM  2'h0
`define CMWSS_RGN_EXT  2'h1
`define CMWSS_RGN_IO   2'h2
`define CMWSS_RGN_ROM  2'h3
// ----------------------------------------
// counter presets
// ----------------------------------------
`define CMWSS_BYTE_START 2'h3
`define CMWSS_WAIT_START 2'h2
`define CMWSS_BYTE_LAST  2'h0
`define CMWSS_WAIT_LAST  2'h0
// i/o strobe active while wait counter at or below this
`define CMWSS_IO_STROBE  2'h1
`endif

// *** testbench/cmwss_monitor.sv ***
`default_nettype none
module cmwss_monitor (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [31:0] cpuAddr,
    input wire logic        extReady,
    input wire logic        procClk,
    input wire logic        addrLatchEn,
    input wire logic [31:0] latchedAddr,
    input wire logic        procRun,
    input wire logic        romSelectN,
    input wire logic [1:0]  rom_byte_index,
    input wire logic [1:0]  wait_phase_counter,
    input wire logic        extSelectN
);
    timeunit 1ns/1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence extWait; !extSelectN && !procRun; endsequence
    clk_inv_a: assert property (procClk != addrLatchEn) else $error("bad clock");
    latch_pass_a: assert property (@(negedge ref_clk) addrLatchEn && latchedAddr == cpuAddr)
        else $error("bad latch");
    reset_preset_a: assert property ($rose(rst_n) |-> !procRun && rom_byte_index == 2'h3
        && wait_phase_counter == 2'h2) else $error("bad reset");
    stall_wait_a: assert property (!romSelectN |-> !procRun) else $error("run in wait");
    wait_step_a: assert property (!romSelectN && wait_phase_counter != 2'h0
        |=> wait_phase_counter == $past(wait_phase_counter) - 2'h1) else $error("bad wait step");
    byte_step_a: assert property (rom_byte_index != $past(rom_byte_index) && rom_byte_index != 2'h3
        |-> $past(wait_phase_counter) == 2'h0) else $error("bad byte step");
    ext_done_a: assert property (extWait ##0 extReady |=> procRun) else $error("ext late");
    ext_hold_a: assert property (extWait ##0 !extReady |=> !procRun) else $error("ext early");
endmodule
bind cmwss_sequencer cmwss_monitor u_cmwss_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .cpuAddr(cpuAddr),
    .extReady(extReady), .procClk(procClk), .addrLatchEn(addrLatchEn), .latchedAddr(latchedAddr),
    .procRun(procRun), .romSelectN(romSelectN), .rom_byte_index(rom_byte_index),
    .wait_phase_counter(wait_phase_counter), .extSelectN(extSelectN));
`default_nettype wire

// *** testbench/cmwss_ext_model.sv ***
`default_nettype none
module cmwss_ext_model (
    input  wire logic       ref_clk,
    input  wire logic       extSelectN,
    input  wire logic [3:0] stallCycles,
    output wire logic       extReady
);
    timeunit 1ns/1ps;
    logic [3:0] heldCnt = 4'h0;
    always @(negedge ref_clk) begin
        heldCnt <= extSelectN ? 4'h0 : heldCnt + 4'h1;
    end
    // pull-up while deselected; slow peripheral holds ready low
    assign extReady = extSelectN | (heldCnt >= stallCycles);
endmodule
`default_nettype wire

// *** testbench/tb_cpu_memory_wait_state_sequencer.sv ***
`default_nettype none
module tb_cpu_memory_wait_state_sequencer;
    timeunit 1ns/1ps;
    logic        ref_clk = 1'h0, rst_n = 1'h0, memReqN = 1'h1, seqCycle = 1'h0, readCycle = 1'h1;
    logic [31:0] cpuAddr = 32'h0;
    logic [3:0]  stallCycles = 4'h0;
    logic        extReady, procRun, romSelN, ioStrN, extSelN, sramSelN;
    logic [7:0]  sramLow = 8'h00, ioLow = 8'h00, romLow = 8'h00;
    logic [1:0]  byteIdx, waitCnt;
    int          n_fail = 0, check_count = 0;
    always #5 ref_clk = ~ref_clk;
    cmwss_sequencer u_cmwss_sequencer (.ref_clk(ref_clk), .rst_n(rst_n), .cpuAddr(cpuAddr), .memReqN(memReqN),
        .seqCycle(seqCycle), .readCycle(readCycle), .extReady(extReady), .procClk(), .addrLatchEn(),
        .latchedAddr(), .procRun(procRun), .sram_select_n(sramSelN), .romSelectN(romSelN),
        .rom_byte_index(byteIdx),
        .wait_phase_counter(waitCnt), .ioStrobeN(ioStrN), .extSelectN(extSelN));
    cmwss_ext_model u_cmwss_ext_model (.ref_clk(ref_clk), .extSelectN(extSelN), .stallCycles(stallCycles),
        .extReady(extReady));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %0t seen %0h want %0h", $time, seen, want);
        end
    endtask
    // cycles from request to the active cycle, decode included; select cycles counted on the way
    task automatic access(input logic [31:0] a, input logic sq, input logic rd, output logic [7:0] n);
        n = 8'h00;
        sramLow = 8'h00;
        ioLow = 8'h00;
        romLow = 8'h00;
        @(negedge ref_clk);
        // a new request is set up at the falling edge, midway through the core's last active cycle
        {cpuAddr, memReqN, seqCycle, readCycle} = {a, 1'h0, sq, rd};
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (sramSelN === 1'h0)
                sramLow++;
            if (ioStrN === 1'h0)
                ioLow++;
            if (romSelN === 1'h0)
                romLow++;
        end while (procRun !== 1'h1 && n < 8'h40);
    endtask
    task automatic t_ram;
        logic [7:0] n;
        access(32'h0000_0100, 1'h0, 1'h1, n);
        check(n, 8'h02);
        check(sramLow, 8'h02);
        access(32'h0000_0104, 1'h1, 1'h1, n);
        check(n, 8'h01);
        check(sramLow, 8'h01);
        access(32'h0000_0108, 1'h0, 1'h0, n);
        check(n, 8'h03);
        check(sramLow, 8'h01);
        @(negedge ref_clk);
        memReqN = 1'h1;
        access(32'h0000_010C, 1'h1, 1'h1, n);
        check(n, 8'h01);
        check(sramLow, 8'h01);
    endtask
    task automatic t_ext;
        logic [7:0] n;
        stallCycles = 4'h3;
        access(32'h4000_0000, 1'h0, 1'h1, n);
        check(n, 8'h05);
        stallCycles = 4'h0;
        access(32'h4000_0010, 1'h0, 1'h1, n);
        check(n, 8'h03);
        access(32'h4000_0014, 1'h1, 1'h1, n);
        check(n, 8'h01);
    endtask
    task automatic t_rom_io;
        logic [7:0] n;
        access(32'hC000_0000, 1'h0, 1'h1, n);
        check(n, 8'h0E);
        check(romLow, 8'h0C);
        access(32'h8000_0000, 1'h0, 1'h1, n);
        check(n, 8'h05);
        check(ioLow, 8'h02);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        check({procRun, byteIdx, waitCnt, romSelN, extSelN, ioStrN}, 8'h77);
        rst_n = 1'h1;
        t_ram();
        t_ext();
        t_rom_io();
        report_and_stop();
    end
endmodule
`default_nettype wire
